// file: pkg/nvm_seq_pkg.sv
// Constants for the flash row erase and block program sequencer
package nvm_seq_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [11:0] ADDR_IRQ_EN2   = 12'h0fa0;
  localparam logic [11:0] ADDR_IRQ_FLG2  = 12'h0fa1;
  localparam logic [11:0] ADDR_IRQ_PRI2  = 12'h0fa2;
  localparam logic [11:0] ADDR_NVM_CTRL  = 12'h0fa6;
  localparam logic [11:0] ADDR_NVM_KEY   = 12'h0fa7;
  localparam logic [11:0] ADDR_IRQ_CTRL  = 12'h0ff2;
  localparam logic [11:0] ADDR_TAB_LATCH = 12'h0ff5;
  localparam logic [11:0] ADDR_PTR_L     = 12'h0ff6;
  localparam logic [11:0] ADDR_PTR_H     = 12'h0ff7;
  localparam logic [11:0] ADDR_PTR_U     = 12'h0ff8;
  localparam logic [11:0] ADDR_TAB_WRITE = 12'h0ffc;

  // Control register fields and done flag bit
  localparam int CTL_PMS   = 7;
  localparam int CTL_CFG   = 6;
  localparam int CTL_FREE  = 4;
  localparam int CTL_ERR   = 3;
  localparam int CTL_WR_EN = 2;
  localparam int CTL_START = 1;
  localparam int FLG_DONE  = 4;

  // Unlock key values
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Reset values and register masks
  localparam logic [7:0] RST_IRQ_PRI2 = 8'h1f;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] CTL_MASK     = 8'hdf;
  localparam logic [7:0] FLG2_MASK    = 8'h1f;

  // Geometry
  localparam int PTR_W      = 22;
  localparam int ROW_LSB    = 6;
  localparam int BLK_LSB    = 3;
  localparam int NUM_HOLD   = 8;
  localparam int IDX_LSB    = 2;

  // Long write time, about 2 ms at 125 MHz
  localparam int CLK_MHZ      = 125;
  localparam int LONG_WR_US   = 2000;
  localparam int LONG_WR_CYC  = LONG_WR_US * CLK_MHZ;

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} seq_state_e;

endpackage : nvm_seq_pkg

// file: hw/nvm_hold_bank.sv
`timescale 1ns/10ps
// Eight byte holding registers loaded by table writes
module nvm_hold_bank
  import nvm_seq_pkg::*;
#(
  parameter int DEPTH = NUM_HOLD
) (
  input  wire logic                     CLK,
  input  wire logic                     NRST,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [7:0]               wr_data,
  output logic [DEPTH*8-1:0]            block
);

  logic [7:0] hold_q [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_hold
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        hold_q[i] <= RST_ZERO;
      end else if (wr_en && wr_idx == ($clog2(DEPTH))'(i)) begin
        hold_q[i] <= wr_data;
      end
    end
    assign block[i*8 +: 8] = hold_q[i];
  end

endmodule : nvm_hold_bank

// file: hw/nvm_flash_seq.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
// Flash row erase and block program sequencer with APB registers
module nvm_flash_seq
  import nvm_seq_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_WR_CYC
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [13:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXT_RESET_PIN,
  input  wire logic        WDT_RESET,
  output logic             CPU_STALL,
  output logic             FLASH_ERASE,
  output logic             FLASH_PROG,
  output logic [15:0]      FLASH_ROW,
  output logic [18:0]      FLASH_BLOCK,
  output logic [63:0]      FLASH_DATA
);

  // Registers
  logic [7:0]         irq_en2_q, irq_flg2_q, irq_pri2_q, irq_ctrl_q;
  logic [7:0]         ctl_q, tab_latch_q;
  logic [PTR_W-1:0]   ptr_q;
  logic [1:0]         key_q;
  logic [31:0]        cnt_q;
  seq_state_e         state_q;
  logic [31:0]        prdata_q;
  logic               pready_q, pslverr_q, stall_q, erase_q, prog_q;
  logic [15:0]        row_q;
  logic [18:0]        blk_q;
  logic [63:0]        data_q;
  logic               rp_s1, rp_s2, wd_s1, wd_s2;
  logic [63:0]        hold_block;

  // Bus decode
  wire setup   = PSEL && !PENABLE;
  // Word index of the byte address; misaligned accesses never write
  wire [11:0] reg_idx = PADDR[13:IDX_LSB];
  wire word_ok = PADDR[IDX_LSB-1:0] == '0;
  wire wr_acc  = setup && PWRITE && word_ok;
  wire rd_acc  = setup && !PWRITE;
  wire [7:0] wd = PWDATA[7:0];
  wire hit_en2 = reg_idx == ADDR_IRQ_EN2;
  wire hit_flg = reg_idx == ADDR_IRQ_FLG2;
  wire hit_pri = reg_idx == ADDR_IRQ_PRI2;
  wire hit_ctl = reg_idx == ADDR_NVM_CTRL;
  wire hit_key = reg_idx == ADDR_NVM_KEY;
  wire hit_ic  = reg_idx == ADDR_IRQ_CTRL;
  wire hit_lat = reg_idx == ADDR_TAB_LATCH;
  wire hit_pl  = reg_idx == ADDR_PTR_L;
  wire hit_ph  = reg_idx == ADDR_PTR_H;
  wire hit_pu  = reg_idx == ADDR_PTR_U;
  wire hit_tw  = reg_idx == ADDR_TAB_WRITE;
  wire mapped  = word_ok && (hit_en2 | hit_flg | hit_pri | hit_ctl | hit_key | hit_ic |
                 hit_lat | hit_pl | hit_ph | hit_pu | hit_tw);
  wire busy    = state_q != ST_IDLE;

  // Unlock and start conditions
  wire key_first  = wr_acc && hit_key && wd == KEY_FIRST;
  wire key_second = wr_acc && hit_key && wd == KEY_SECOND && key_q == 2'd1;
  wire start_req  = wr_acc && hit_ctl && wd[CTL_START] && !busy;
  wire start_ok   = start_req && key_q == 2'd2 && ctl_q[CTL_WR_EN] && wd[CTL_PMS] && !wd[CTL_CFG];
  wire long_end   = busy && cnt_q == 32'(LONG_CYCLES - 1);
  wire abort_evt  = busy && (rp_s2 || wd_s2);
  wire tab_wr     = wr_acc && hit_tw && !busy;

  // Read mux
  wire [7:0] rd_byte = hit_en2 ? irq_en2_q :
                       hit_flg ? irq_flg2_q :
                       hit_pri ? irq_pri2_q :
                       hit_ctl ? ctl_q :
                       hit_ic  ? irq_ctrl_q :
                       hit_lat ? tab_latch_q :
                       hit_pl  ? ptr_q[7:0] :
                       hit_ph  ? ptr_q[15:8] :
                       hit_pu  ? {2'b00, ptr_q[21:16]} :
                       RST_ZERO;

  // Reset pin and watchdog synchronisers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rp_s1 <= 1'b0;
      rp_s2 <= 1'b0;
      wd_s1 <= 1'b0;
      wd_s2 <= 1'b0;
    end else begin
      rp_s1 <= EXT_RESET_PIN;
      rp_s2 <= rp_s1;
      wd_s1 <= WDT_RESET;
      wd_s2 <= wd_s1;
    end
  end

  // APB answer, one wait-free access phase
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= rd_acc ? {24'h00_0000, rd_byte} : '0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      key_q <= 2'd0;
    end else if (key_second) begin
      key_q <= 2'd2;
    end else if (key_first) begin
      key_q <= 2'd1;
    end else if (setup) begin
      key_q <= 2'd0;
    end
  end

  // Plain read/write registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_en2_q   <= RST_ZERO;
      irq_pri2_q  <= RST_IRQ_PRI2;
      irq_ctrl_q  <= RST_ZERO;
      tab_latch_q <= RST_ZERO;
    end else begin
      if (wr_acc && hit_en2) irq_en2_q <= wd & FLG2_MASK;
      if (wr_acc && hit_pri) irq_pri2_q <= wd & FLG2_MASK;
      if (wr_acc && hit_ic) irq_ctrl_q <= wd;
      if (wr_acc && hit_lat) tab_latch_q <= wd;
    end
  end

  // 22-bit table pointer; write port auto-increments low 21 bits
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ptr_q <= '0;
    end else if (tab_wr) begin
      ptr_q[20:0] <= ptr_q[20:0] + 21'd1;
    end else if (wr_acc && !busy) begin
      if (hit_pl) ptr_q[7:0] <= wd;
      if (hit_ph) ptr_q[15:8] <= wd;
      if (hit_pu) ptr_q[21:16] <= wd[5:0];
    end
  end

  // Table write hits only a holding register
  nvm_hold_bank #(
    .DEPTH (NUM_HOLD)
  ) u_hold (
    .CLK     (CLK),
    .NRST    (NRST),
    .wr_en   (tab_wr),
    .wr_idx  (ptr_q[BLK_LSB-1:0]),
    .wr_data (tab_latch_q),
    .block   (hold_block)
  );

  // Control register with hardware-owned start and abort bits
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctl_q <= RST_ZERO;
    end else begin
      if (wr_acc && hit_ctl && !busy) begin
        ctl_q[CTL_PMS]  <= wd[CTL_PMS];
        ctl_q[CTL_CFG]  <= wd[CTL_CFG];
        ctl_q[CTL_FREE] <= wd[CTL_FREE];
        ctl_q[CTL_WR_EN] <= wd[CTL_WR_EN];
        ctl_q[CTL_ERR]  <= wd[CTL_ERR] & ctl_q[CTL_ERR];
      end
      // Set by software, cleared at end or on abort
      if (start_ok) begin
        ctl_q[CTL_START] <= 1'b1;
      end else if (long_end || abort_evt) begin
        ctl_q[CTL_START] <= 1'b0;
      end
      if (abort_evt) ctl_q[CTL_ERR] <= 1'b1;
    end
  end

  // Done flag, set wins over clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_flg2_q <= RST_ZERO;
    end else begin
      if (wr_acc && hit_flg) irq_flg2_q <= wd & FLG2_MASK;
      if (long_end) irq_flg2_q[FLG_DONE] <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (start_ok) state_q <= wd[CTL_FREE] ? ST_ERASE : ST_PROG;
        end
        ST_ERASE, ST_PROG: begin
          cnt_q <= cnt_q + 32'd1;
          if (long_end || abort_evt) state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // Flash array commands and CPU stall
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      stall_q <= 1'b0;
      erase_q <= 1'b0;
      prog_q  <= 1'b0;
      row_q   <= '0;
      blk_q   <= '0;
      data_q  <= '0;
    end else begin
      stall_q <= start_ok || (busy && !long_end && !abort_evt);
      erase_q <= long_end && state_q == ST_ERASE;
      prog_q  <= long_end && state_q == ST_PROG;
      if (start_ok) begin
        row_q  <= ptr_q[PTR_W-1:ROW_LSB];
        blk_q  <= ptr_q[PTR_W-1:BLK_LSB];
        data_q <= hold_block;
      end
    end
  end

  assign PRDATA      = prdata_q;
  assign PREADY      = pready_q;
  assign PSLVERR     = pslverr_q;
  assign CPU_STALL   = stall_q;
  assign FLASH_ERASE = erase_q;
  assign FLASH_PROG  = prog_q;
  assign FLASH_ROW   = row_q;
  assign FLASH_BLOCK = blk_q;
  assign FLASH_DATA  = data_q;

  // Start needs key and enable
  property p_start_key;
    @(posedge CLK) disable iff (!NRST)
      $rose(busy) |-> $past(key_q, 1) == 2'd2 && $past(ctl_q[CTL_WR_EN], 1);
  endproperty
  a_start_key: assert property (p_start_key) else $error("Long write began without key or enable");

  // Stall covers the run
  property p_stall;
    @(posedge CLK) disable iff (!NRST)
      CPU_STALL == busy;
  endproperty
  a_stall: assert property (p_stall) else $error("CPU not stalled during long write");

  // Done flag follows end
  property p_done;
    @(posedge CLK) disable iff (!NRST)
      long_end |=> irq_flg2_q[FLG_DONE] && !ctl_q[CTL_START] && state_q == ST_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("Completion not flagged");

  // Abort sets error
  property p_abort;
    @(posedge CLK) disable iff (!NRST)
      abort_evt |=> ctl_q[CTL_ERR] && !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("Abort flag not set");

  // Erase pulse only after erase run
  property p_erase;
    @(posedge CLK) disable iff (!NRST)
      FLASH_ERASE |-> $past(state_q, 1) == ST_ERASE && !FLASH_PROG;
  endproperty
  a_erase: assert property (p_erase) else $error("Erase pulse without erase run");

  // Program pulse only after program run
  property p_prog;
    @(posedge CLK) disable iff (!NRST)
      FLASH_PROG |-> $past(state_q, 1) == ST_PROG;
  endproperty
  a_prog: assert property (p_prog) else $error("Program pulse without program run");

  // Key register reads zero
  property p_key_read;
    @(posedge CLK) disable iff (!NRST)
      rd_acc && hit_key |=> PRDATA == 32'h0000_0000 && PREADY;
  endproperty
  a_key_read: assert property (p_key_read) else $error("Key register read not zero");

  // Intervening access disarms key
  property p_disarm;
    @(posedge CLK) disable iff (!NRST)
      setup && !hit_key && !key_q[1] |=> key_q == 2'd0;
  endproperty
  a_disarm: assert property (p_disarm) else $error("Key not disarmed");

endmodule : nvm_flash_seq

// file: bench/cpu_core_model.sv
// CPU core model: APB master running the firmware write sequences
`timescale 1ns/10ps
module cpu_core_model
  import nvm_seq_pkg::*;
(
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [13:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  output logic             hang
);
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 14'h0000;
    pwdata  = 32'h0000_0000;
    hang    = 1'b0;
  end

  // One transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] adr, input logic [7:0] dat);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {adr, 2'b00};
    pwdata  <= {24'h00_0000, dat};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 64) hang <= 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~{adr, 2'b00}; // No stale address after release
    pwdata  <= ~pwdata; // No stale data after release
  endtask : xfer

  task automatic set_ptr(input logic [21:0] p);
    xfer(1'b1, ADDR_PTR_L, p[7:0]);
    xfer(1'b1, ADDR_PTR_H, p[15:8]);
    xfer(1'b1, ADDR_PTR_U, {2'b00, p[21:16]});
  endtask : set_ptr

  task automatic long_write(input logic erase);
    xfer(1'b1, ADDR_NVM_CTRL, 8'h84 | {3'b000, erase, 4'h0});
    xfer(1'b1, ADDR_NVM_KEY, KEY_FIRST);
    xfer(1'b1, ADDR_NVM_KEY, KEY_SECOND);
    xfer(1'b1, ADDR_NVM_CTRL, 8'h86 | {3'b000, erase, 4'h0});
  endtask : long_write
endmodule : cpu_core_model

// file: bench/tb_top.sv
// Self-checking bench for the flash erase and program sequencer
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
  begin \
    cmp_count++; \
    if ((gt) !== (ex)) begin \
      n_fail++; \
      $display("mismatch %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module tb_top;
  import nvm_seq_pkg::*;
  localparam int LONG = 20;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic        ext_rst, wdt_rst, stall, f_erase, f_prog, hang;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] f_row;
  logic [18:0] f_blk;
  logic [63:0] f_data, hold;
  logic [21:0] p, e;
  logic [33:0] rnote;
  logic [100:0] fnote;
  logic [33:0] rd_q[$];
  logic [100:0] fl_q[$];
  int          n_fail, cmp_count, stall_n, last_stall, i;
  logic [11:0] ra[10] = '{ADDR_IRQ_EN2, ADDR_IRQ_FLG2, ADDR_IRQ_PRI2, ADDR_NVM_CTRL, ADDR_NVM_KEY,
                          ADDR_IRQ_CTRL, ADDR_TAB_LATCH, ADDR_PTR_L, ADDR_PTR_H, ADDR_PTR_U};
  logic [7:0]  pre[6] = '{8'h84, 8'h80, 8'hc4, 8'h04, 8'h84, 8'h84};
  logic [7:0]  k1[6]  = '{8'h00, KEY_FIRST, KEY_FIRST, KEY_FIRST, KEY_SECOND, KEY_FIRST};
  logic [7:0]  k2[6]  = '{8'h00, KEY_SECOND, KEY_SECOND, KEY_SECOND, KEY_FIRST, KEY_SECOND};

  nvm_flash_seq #(.LONG_CYCLES(LONG)) u_dut (
    .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_RESET_PIN(ext_rst), .WDT_RESET(wdt_rst), .CPU_STALL(stall), .FLASH_ERASE(f_erase),
    .FLASH_PROG(f_prog), .FLASH_ROW(f_row), .FLASH_BLOCK(f_blk), .FLASH_DATA(f_data));

  cpu_core_model u_cpu (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .hang(hang));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, d);
  endtask : wr

  // Note the expected answer, then read
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic err);
    rd_q.push_back({~err, err, 24'h00_0000, x});
    u_cpu.xfer(1'b0, a, 8'h00);
  endtask : rd

  // Bounded wait for a long write to end
  task automatic wait_done(input logic chk);
    int n;
    logic seen;
    seen = 1'b0;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (stall === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    if (n == 400) begin
      n_fail++;
      give_verdict();
    end else begin
      @(posedge clk);
      if (chk) `CHK("stall cycles", LONG, last_stall)
    end
  endtask : wait_done

  // Scoreboard: oldest note checked whenever a result shows
  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      rnote = rd_q.size() ? rd_q.pop_front() : 34'h3_ffff_ffff;
      `CHK("read error", rnote[32], pslverr)
      if (rnote[33]) `CHK("read data", rnote[31:0], prdata)
    end
    if (f_erase === 1'b1 || f_prog === 1'b1) begin
      fnote = fl_q.size() ? fl_q.pop_front() : '0;
      `CHK("flash op", fnote, {f_erase, f_prog, f_row, f_blk, f_data})
    end
  end

  // Stall length of the last long write
  always @(posedge clk) begin
    if (stall === 1'b1) stall_n <= stall_n + 1;
    else if (stall_n != 0) begin
      last_stall <= stall_n;
      stall_n    <= 0;
    end
  end

  always @(posedge hang) begin
    n_fail++;
    give_verdict();
  end

  // Main sequence
  initial begin
    nrst    = 1'b0;
    ext_rst = 1'b0;
    wdt_rst = 1'b0;
    stall_n = 0;
    r       = 32'd84325;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 10; i++) rd(ra[i], (i == 2) ? RST_IRQ_PRI2 : RST_ZERO, 1'b0);
    rd(12'h0f00, 8'h00, 1'b1);
    // Table writes from a pointer that wraps its low 21 bits
    r = xs(r);
    p = {r[21], 21'h1f_fffd};
    u_cpu.set_ptr(p);
    for (i = 0; i < 8; i++) begin
      r = xs(r);
      hold[8*((5+i)%8) +: 8] = r[7:0];
      wr(ADDR_TAB_LATCH, r[7:0]);
      wr(ADDR_TAB_WRITE, 8'h00);
    end
    rd(ADDR_PTR_L, 8'h05, 1'b0);
    rd(ADDR_PTR_U, {2'b00, p[21], 5'h00}, 1'b0);
    // Row erase at a random pointer
    r = xs(r);
    e = r[21:0];
    u_cpu.set_ptr(e);
    fl_q.push_back({2'b10, e[21:6], e[21:3], hold});
    u_cpu.long_write(1'b1);
    wait_done(1'b1);
    rd(ADDR_NVM_CTRL, 8'h94, 1'b0);
    rd(ADDR_IRQ_FLG2, 8'h10, 1'b0);
    wr(ADDR_IRQ_FLG2, 8'h00);
    rd(ADDR_IRQ_FLG2, 8'h00, 1'b0);
    // Block program at the loaded block
    u_cpu.set_ptr(p);
    fl_q.push_back({2'b01, p[21:6], p[21:3], hold});
    u_cpu.long_write(1'b0);
    wait_done(1'b1);
    rd(ADDR_NVM_CTRL, 8'h84, 1'b0);
    rd(ADDR_IRQ_FLG2, 8'h10, 1'b0);
    // Starts that must be refused
    for (i = 0; i < 6; i++) begin
      wr(ADDR_NVM_CTRL, pre[i]);
      wr(ADDR_NVM_KEY, k1[i]);
      if (i == 5) rd(ADDR_NVM_KEY, 8'h00, 1'b0);
      wr(ADDR_NVM_KEY, k2[i]);
      wr(ADDR_NVM_CTRL, pre[i] | 8'h02);
      repeat (3) @(posedge clk);
      `CHK("stall on refused start", 1'b0, stall)
      rd(ADDR_NVM_CTRL, pre[i], 1'b0);
    end
    repeat (2 * LONG) @(posedge clk);
    // Reset pin and watchdog events in mid write
    for (i = 0; i < 2; i++) begin
      u_cpu.long_write(1'b0);
      repeat (6) @(posedge clk);
      ext_rst <= (i == 0);
      wdt_rst <= (i == 1);
      repeat (4) @(posedge clk);
      ext_rst <= 1'b0;
      wdt_rst <= 1'b0;
      // Abort has already ended the stall, well before the timer would
      repeat (2) @(posedge clk);
      `CHK("stall after abort", 1'b0, stall)
      rd(ADDR_NVM_CTRL, 8'h8c, 1'b0);
      wr(ADDR_NVM_CTRL, 8'h84);
      rd(ADDR_NVM_CTRL, 8'h84, 1'b0);
    end
    repeat (2 * LONG) @(posedge clk);
    give_verdict();
  end
endmodule : tb_top
